// ### io_read_watchdog_timer.sv
// i/o read watchdog timer: enable/refresh and disable by host port reads
//
// Overview of operation
// - a read of the enable port while disabled starts counting the selected period.
// - a read of the disable port stops the watchdog so no timeout action follows.
// - a further enable-port read while enabled acts as a refresh.
// - each refresh restarts the period count from zero.
// - reaching the period without refresh asserts system reset or nmi per the action select.
// - after power-on the watchdog is disabled and does not count until an enable read.
// - action select: 2-3 (default) gives reset, 1-2 gives nmi, open disables the watchdog.
// - period select bit2/bit1/bit0 pick 1, 2, 10, 20, 110 or 220 seconds.
// - a select input counts as on when its pins are shorted and off when open.
// - besides the action and period select jumpers and the arst_n_i reset, the watchdog is controlled only by read cycles to its two i/o ports.
`include "io_wdt_map.svh"

module io_read_watchdog_timer #(
  parameter int unsigned TICKS_PER_SEC = `WDT_TICKS_PER_SEC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_n_i,
  input wire logic act_sel12_short_n_i,
  input wire logic act_sel23_short_n_i,
  input wire logic period_sel_bit2_short_n_i,
  input wire logic period_sel_bit1_short_n_i,
  input wire logic period_sel_bit0_short_n_i,
  output logic [7:0] io_data_o,
  output logic io_data_oe_o,
  output logic sys_reset_o,
  output logic nmi_o
);

  // -----------------------------------------------------------------
  // pin synchroniser
  // -----------------------------------------------------------------
  io_wdt_pkg::wdt_pins_t pins_raw;
  io_wdt_pkg::wdt_pins_t sync1;
  io_wdt_pkg::wdt_pins_t sync2;
  io_wdt_pkg::wdt_pins_t next_sync1;
  io_wdt_pkg::wdt_pins_t next_sync2;
  logic rd_prev;
  logic next_rd_prev;

  // raw pin levels only; every decode waits until after both stages
  always_comb begin
    pins_raw.addr = io_addr_i;
    pins_raw.rd_n = io_rd_n_i;
    pins_raw.act12_short_n = act_sel12_short_n_i;
    pins_raw.act23_short_n = act_sel23_short_n_i;
    pins_raw.period_short_n = {period_sel_bit2_short_n_i, period_sel_bit1_short_n_i,
                               period_sel_bit0_short_n_i};
    next_sync1 = pins_raw;
    next_sync2 = sync1;
    next_rd_prev = sync2.rd_n;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= '{addr: 16'h0000, rd_n: 1'b1, act12_short_n: 1'b1, act23_short_n: 1'b1,
                 period_short_n: 3'h7};
      sync2 <= '{addr: 16'h0000, rd_n: 1'b1, act12_short_n: 1'b1, act23_short_n: 1'b1,
                 period_short_n: 3'h7};
      rd_prev <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      rd_prev <= next_rd_prev;
    end
  end

  // -----------------------------------------------------------------
  // port decode and jumper decode
  // -----------------------------------------------------------------
  logic rd_start;
  logic hit_en;
  logic hit_dis;
  logic hit_any;
  io_wdt_pkg::wdt_action_t action;
  logic [7:0] period_secs;
  logic act12_on;
  logic act23_on;
  logic [2:0] period_on;

  // jumpers pull low when shorted, so on is the inverted synchronised pin
  always_comb begin
    act12_on = ~sync2.act12_short_n;
    act23_on = ~sync2.act23_short_n;
    period_on = ~sync2.period_short_n;
  end

  // one event per read cycle, taken on the falling read strobe
  always_comb begin
    rd_start = rd_prev && !sync2.rd_n;
    hit_en = rd_start && (sync2.addr == `WDT_PORT_ENABLE_REFRESH);
    hit_dis = rd_start && (sync2.addr == `WDT_PORT_DISABLE);
    hit_any = !sync2.rd_n && ((sync2.addr == `WDT_PORT_ENABLE_REFRESH) ||
                              (sync2.addr == `WDT_PORT_DISABLE));
  end

  // both links fitted is treated as the default reset choice
  always_comb begin
    if (act23_on) begin
      action = io_wdt_pkg::ACT_RESET;
    end else if (act12_on) begin
      action = io_wdt_pkg::ACT_NMI;
    end else begin
      action = io_wdt_pkg::ACT_OFF;
    end
  end

  // unlisted codes fall back to the shortest period, the safe side
  always_comb begin
    case (period_on)
      3'b111: period_secs = `WDT_PERIOD_1S;
      3'b011: period_secs = `WDT_PERIOD_2S;
      3'b101: period_secs = `WDT_PERIOD_10S;
      3'b001: period_secs = `WDT_PERIOD_20S;
      3'b110: period_secs = `WDT_PERIOD_110S;
      3'b010: period_secs = `WDT_PERIOD_220S;
      default: period_secs = `WDT_PERIOD_1S;
    endcase
  end

  // -----------------------------------------------------------------
  // second time base
  // -----------------------------------------------------------------
  logic tick;
  logic tick_clear;

  wdt_tick_gen #(
    .TICKS(TICKS_PER_SEC)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clear_i(tick_clear),
    .tick_o(tick)
  );

  // -----------------------------------------------------------------
  // watchdog state machine
  // -----------------------------------------------------------------
  io_wdt_pkg::wdt_state_t state;
  io_wdt_pkg::wdt_state_t next_state;
  logic [7:0] sec_cnt;
  logic [7:0] next_sec_cnt;
  logic [4:0] pulse_cnt;
  logic [4:0] next_pulse_cnt;
  io_wdt_pkg::wdt_action_t fire_kind;
  io_wdt_pkg::wdt_action_t next_fire_kind;
  logic expired;

  // the sub-second phase restarts with every refresh
  always_comb begin
    tick_clear = hit_en || (state != io_wdt_pkg::ST_COUNTING);
    expired = tick && ((sec_cnt + 8'h01) >= period_secs);
  end

  always_comb begin
    next_state = state;
    next_sec_cnt = sec_cnt;
    next_pulse_cnt = pulse_cnt;
    next_fire_kind = fire_kind;
    case (state)
      io_wdt_pkg::ST_DISABLED: begin
        if (hit_en && (action != io_wdt_pkg::ACT_OFF)) begin
          next_state = io_wdt_pkg::ST_COUNTING;
          next_sec_cnt = 8'h00;
        end
      end
      io_wdt_pkg::ST_COUNTING: begin
        if (hit_dis || (action == io_wdt_pkg::ACT_OFF)) begin
          next_state = io_wdt_pkg::ST_DISABLED;
          next_sec_cnt = 8'h00;
        end else if (hit_en) begin
          next_sec_cnt = 8'h00;
        end else if (expired) begin
          next_state = io_wdt_pkg::ST_FIRING;
          next_pulse_cnt = 5'(`WDT_PULSE_CYC - 1);
          next_fire_kind = action;
          next_sec_cnt = 8'h00;
        end else if (tick) begin
          next_sec_cnt = sec_cnt + 8'h01;
        end
      end
      io_wdt_pkg::ST_FIRING: begin
        // a started pulse always completes; a cut reset is worse than none
        if (pulse_cnt == 5'h00) begin
          next_state = io_wdt_pkg::ST_DISABLED;
        end else begin
          next_pulse_cnt = pulse_cnt - 5'h01;
        end
      end
      default: begin
        next_state = io_wdt_pkg::ST_DISABLED;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= io_wdt_pkg::ST_DISABLED;
      sec_cnt <= 8'h00;
      pulse_cnt <= 5'h00;
      fire_kind <= io_wdt_pkg::ACT_RESET;
    end else begin
      state <= next_state;
      sec_cnt <= next_sec_cnt;
      pulse_cnt <= next_pulse_cnt;
      fire_kind <= next_fire_kind;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  logic [7:0] next_data;
  logic next_data_oe;
  logic next_reset;
  logic next_nmi;

  always_comb begin
    next_reset = (next_state == io_wdt_pkg::ST_FIRING) &&
                 (next_fire_kind == io_wdt_pkg::ACT_RESET);
    next_nmi = (next_state == io_wdt_pkg::ST_FIRING) &&
               (next_fire_kind == io_wdt_pkg::ACT_NMI);
    next_data_oe = hit_any;
    next_data = `WDT_STAT_RESET;
    next_data[`WDT_STAT_RUN_BIT] = (state == io_wdt_pkg::ST_COUNTING);
    next_data[`WDT_STAT_FIRE_BIT] = (state == io_wdt_pkg::ST_FIRING);
    next_data[`WDT_STAT_ACT_LSB +: 2] = action;
    next_data[`WDT_STAT_PER_LSB +: 3] = period_on;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_data_o <= `WDT_STAT_RESET;
      io_data_oe_o <= 1'b0;
      sys_reset_o <= 1'b0;
      nmi_o <= 1'b0;
    end else begin
      io_data_o <= next_data;
      io_data_oe_o <= next_data_oe;
      sys_reset_o <= next_reset;
      nmi_o <= next_nmi;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_enable_starts: assert property (
    (state == io_wdt_pkg::ST_DISABLED) && hit_en && (action != io_wdt_pkg::ACT_OFF)
    |=> (state == io_wdt_pkg::ST_COUNTING) && (sec_cnt == 8'h00))
    else $error("enable read did not start the count");

  chk_disable_stops: assert property (
    (state == io_wdt_pkg::ST_COUNTING) && hit_dis
    |=> (state == io_wdt_pkg::ST_DISABLED) ##1 !sys_reset_o && !nmi_o)
    else $error("disable read did not stop the watchdog");

  chk_refresh_restarts: assert property (
    (state == io_wdt_pkg::ST_COUNTING) && hit_en && (action != io_wdt_pkg::ACT_OFF)
    |=> (state == io_wdt_pkg::ST_COUNTING) && (sec_cnt == 8'h00) && !tick)
    else $error("refresh did not restart the count");

  chk_fire_on_expiry: assert property (
    (state == io_wdt_pkg::ST_COUNTING) && expired && !hit_en && !hit_dis &&
    (action != io_wdt_pkg::ACT_OFF)
    |=> (state == io_wdt_pkg::ST_FIRING) ##1 (sys_reset_o != nmi_o))
    else $error("expiry did not raise the timeout action");

  chk_no_early_fire: assert property (
    $rose(sys_reset_o) || $rose(nmi_o)
    |-> $past(state, 2) == io_wdt_pkg::ST_COUNTING)
    else $error("timeout action raised without an expiring count");

  chk_action_kind: assert property (
    (state == io_wdt_pkg::ST_COUNTING) && expired && !hit_en && !hit_dis &&
    (action == io_wdt_pkg::ACT_NMI)
    |-> ##2 nmi_o && !sys_reset_o)
    else $error("nmi setting produced the wrong action");

  chk_open_disables: assert property (
    (action == io_wdt_pkg::ACT_OFF) && $stable(action) && (state != io_wdt_pkg::ST_FIRING)
    |=> state == io_wdt_pkg::ST_DISABLED)
    else $error("open action select left the watchdog running");

  chk_period_decode: assert property (
    ((period_on != 3'b010) || (period_secs == `WDT_PERIOD_220S)) &&
    ((period_on != 3'b011) || (period_secs == `WDT_PERIOD_2S)))
    else $error("period select decoded wrongly");

  chk_idle_quiet: assert property (
    (state == io_wdt_pkg::ST_DISABLED) && !hit_en
    |=> (state == io_wdt_pkg::ST_DISABLED) && (sec_cnt == 8'h00))
    else $error("disabled watchdog started without an enable read");

  chk_port_decode: assert property (
    io_data_oe_o |-> $past(!sync2.rd_n) &&
    ($past(sync2.addr) inside {`WDT_PORT_ENABLE_REFRESH, `WDT_PORT_DISABLE}))
    else $error("data driven outside a watchdog port read");

  chk_pulse_returns: assert property (
    $rose(sys_reset_o) |-> sys_reset_o[*8] ##1 sys_reset_o[*8] ##1
    (!sys_reset_o && (state == io_wdt_pkg::ST_DISABLED)))
    else $error("reset pulse length or return to disabled wrong");

endmodule : io_read_watchdog_timer

// ### io_wdt_map.svh
// offsets, field positions and timing counts of the i/o read watchdog
`ifndef IO_WDT_MAP_SVH
`define IO_WDT_MAP_SVH

// -----------------------------------------------------------------
// i/o port addresses
// -----------------------------------------------------------------
`define WDT_PORT_DISABLE 16'h0045
`define WDT_PORT_ENABLE_REFRESH 16'h0443

// -----------------------------------------------------------------
// status byte returned on a port read
// -----------------------------------------------------------------
`define WDT_STAT_RUN_BIT 0
`define WDT_STAT_FIRE_BIT 1
`define WDT_STAT_ACT_LSB 2
`define WDT_STAT_PER_LSB 4
`define WDT_STAT_RESET 8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define WDT_CLK_PERIOD_NS 100
`define WDT_SECOND_NS 1000000000
`define WDT_TICKS_PER_SEC (`WDT_SECOND_NS / `WDT_CLK_PERIOD_NS)
`define WDT_PULSE_NS 1600
`define WDT_PULSE_CYC ((`WDT_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

// -----------------------------------------------------------------
// periods in seconds
// -----------------------------------------------------------------
`define WDT_PERIOD_1S 8'h01
`define WDT_PERIOD_2S 8'h02
`define WDT_PERIOD_10S 8'h0a
`define WDT_PERIOD_20S 8'h14
`define WDT_PERIOD_110S 8'h6e
`define WDT_PERIOD_220S 8'hdc

`endif

// ### io_wdt_pkg.sv
// types shared by the i/o read watchdog
package io_wdt_pkg;

  typedef enum logic [2:0] {
    ST_DISABLED = 3'b001,
    ST_COUNTING = 3'b010,
    ST_FIRING = 3'b100
  } wdt_state_t;

  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_RESET = 2'b01,
    ACT_NMI = 2'b10
  } wdt_action_t;

  // all pins that arrive from outside the clock domain
  typedef struct packed {
    logic [15:0] addr;
    logic rd_n;
    logic act12_short_n;
    logic act23_short_n;
    logic [2:0] period_short_n;
  } wdt_pins_t;

endpackage : io_wdt_pkg

// ### wdt_tick_gen.sv
// one-second tick generator with synchronous restart
`include "io_wdt_map.svh"

module wdt_tick_gen #(
  parameter int unsigned TICKS = `WDT_TICKS_PER_SEC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clear_i,
  output logic tick_o
);

  logic [23:0] count;
  logic [23:0] next_count;
  logic tick;
  logic next_tick;

  // -----------------------------------------------------------------
  // prescaler
  // -----------------------------------------------------------------
  always_comb begin
    next_count = count + 24'h00_0001;
    next_tick = 1'b0;
    if (clear_i) begin
      next_count = 24'h00_0000;
    end else if (count == 24'(TICKS - 1)) begin
      next_count = 24'h00_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 24'h00_0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tick_o = tick;

endmodule : wdt_tick_gen

// ### io_host_model.sv
// host model that issues i/o read cycles to the watchdog ports
module io_host_model (
  input wire logic clk_i,
  input wire logic [7:0] io_data_i,
  input wire logic io_data_oe_i,
  output logic [15:0] io_addr_o,
  output logic io_rd_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    io_addr_o = 16'hffff;
    io_rd_n_o = 1'b1;
  end

  // ----------------------------------------
  // one read cycle, driven off the sampling edge
  // ----------------------------------------
  task automatic io_read(input logic [15:0] addr, input int hold, output logic [7:0] data,
                         output logic seen);
    @(negedge clk_i);
    seen = 1'b0;
    data = 8'h00;
    io_addr_o = addr;
    io_rd_n_o = 1'b0;
    // strobe low well past the two sync stages
    repeat (hold) begin
      @(negedge clk_i);
      if (io_data_oe_i === 1'b1) begin
        seen = 1'b1;
        data = io_data_i;
      end
    end
    io_rd_n_o = 1'b1;
    // released bus: no stale address left behind
    io_addr_o = ~addr;
    repeat (4) @(negedge clk_i);
  endtask : io_read
endmodule : io_host_model

// ### testbench.sv
// self-checking bench for the i/o read watchdog timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int T = 20;
  localparam int LIMIT = 25000;

  logic clk;
  logic arst_n;
  logic act12_n;
  logic act23_n;
  logic [2:0] per_n;
  logic [15:0] addr;
  logic rd_n;
  logic [7:0] data;
  logic oe;
  logic sys_rst;
  logic nmi;
  logic seen_rst;
  logic seen_nmi;
  logic [7:0] rdat;
  logic rseen;
  int failures;
  int checks;
  int cyc;
  int seed;
  int t0;
  int rise;
  int width;
  int per_s[6] = '{1, 2, 10, 20, 110, 220};
  logic [2:0] on_bits[6] = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2};

  io_read_watchdog_timer #(.TICKS_PER_SEC(T)) dut_u (
    .ref_clk_i(clk), .arst_n_i(arst_n), .io_addr_i(addr), .io_rd_n_i(rd_n),
    .act_sel12_short_n_i(act12_n), .act_sel23_short_n_i(act23_n),
    .period_sel_bit2_short_n_i(per_n[2]), .period_sel_bit1_short_n_i(per_n[1]),
    .period_sel_bit0_short_n_i(per_n[0]), .io_data_o(data), .io_data_oe_o(oe),
    .sys_reset_o(sys_rst), .nmi_o(nmi));

  io_host_model host_u (.clk_i(clk), .io_data_i(data), .io_data_oe_i(oe), .io_addr_o(addr), .io_rd_n_o(rd_n));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic chkv(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chkv

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // window allows for sync delay and the firing step
  function automatic logic win(input int d, input int p);
    return (d >= p * T + 2 && d <= p * T + 10);
  endfunction : win

  task automatic rd(input logic [15:0] a, input int hold);
    host_u.io_read(a, hold, rdat, rseen);
  endtask : rd

  // act 0 open, 1 pins 2-3, 2 pins 1-2; a shorted pair reads low
  task automatic jumpers(input int act, input int idx);
    @(negedge clk);
    act23_n = (act != 1);
    act12_n = (act != 2);
    per_n = ~on_bits[idx];
    seen_rst = 1'b0;
    seen_nmi = 1'b0;
    repeat (4) @(negedge clk);
  endtask : jumpers

  task automatic quiet(input int n);
    seen_rst = 1'b0;
    seen_nmi = 1'b0;
    repeat (n) @(negedge clk);
    chk("reset pulse", 1'b0, seen_rst);
    chk("nmi pulse", 1'b0, seen_nmi);
  endtask : quiet

  task automatic wait_pulse(input int lim);
    rise = -1;
    width = 0;
    for (int i = 0; i < lim && rise < 0; i++) begin
      @(negedge clk);
      if (sys_rst === 1'b1 || nmi === 1'b1) rise = cyc;
    end
    while ((sys_rst === 1'b1 || nmi === 1'b1) && width < 40) begin
      @(negedge clk);
      width++;
    end
  endtask : wait_pulse

  // ----------------------------------------
  // clock, cycle ceiling, pulse monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      failures++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (sys_rst === 1'b1) seen_rst = 1'b1;
    if (nmi === 1'b1) seen_nmi = 1'b1;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    act12_n = 1'b1;
    act23_n = 1'b0;
    per_n = 3'h0;
    seed = 35326;
    seen_rst = 1'b0;
    seen_nmi = 1'b0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset output idle", 1'b0, sys_rst);
    quiet(3 * T);
    for (int k = 0; k < 4; k++) begin
      rd(16'h0443 ^ 16'(($random(seed) & 32'h0000_00ff) | 32'h0000_0100), 6);
      chk("oe on other address", 1'b0, rseen);
    end
    quiet(3 * T);
    $display("test idle done");
    for (int i = 0; i < 6; i++) begin
      jumpers(1, i);
      t0 = cyc;
      rd(16'h0443, 6 + ($random(seed) & 3));
      chk("state after enable", 1'b1, rdat[0]);
      chkv("period pins", 16'(on_bits[i]), 16'(rdat[6:4]));
      chkv("action field", 16'h0001, 16'(rdat[3:2]));
      wait_pulse(per_s[i] * T + 40);
      chk("timeout window", 1'b1, win(rise - t0, per_s[i]));
      chkv("pulse width", 16'h0010, 16'(width));
      chk("nmi on reset select", 1'b0, seen_nmi);
      quiet(per_s[i] * T + 40);
      $display("test period %0d done", per_s[i]);
    end
    jumpers(2, 0);
    t0 = cyc;
    rd(16'h0443, 6);
    chkv("action field", 16'h0002, 16'(rdat[3:2]));
    wait_pulse(T + 40);
    chk("timeout window", 1'b1, win(rise - t0, 1));
    chkv("nmi pulse width", 16'h0010, 16'(width));
    chk("nmi pulse", 1'b1, seen_nmi);
    chk("reset on nmi select", 1'b0, seen_rst);
    $display("test nmi done");
    jumpers(0, 0);
    rd(16'h0443, 6);
    chk("enable with select open", 1'b0, rdat[0]);
    quiet(3 * T);
    $display("test open select done");
    jumpers(1, 1);
    rd(16'h0443, 6);
    for (int k = 0; k < 8; k++) begin
      repeat (2 + ($random(seed) & 15)) @(negedge clk);
      t0 = cyc;
      rd(16'h0443, 6 + ($random(seed) & 3));
      chk("refresh keeps counting", 1'b1, rdat[0]);
    end
    chk("no pulse while refreshed", 1'b0, seen_rst);
    wait_pulse(2 * T + 40);
    chk("timeout from last refresh", 1'b1, win(rise - t0, 2));
    $display("test refresh done");
    jumpers(1, 0);
    rd(16'h0443, 6);
    repeat ($random(seed) & 3) @(negedge clk);
    rd(16'h0045, 6);
    chk("state after disable", 1'b0, rdat[0]);
    chk("oe on disable port", 1'b1, rseen);
    quiet(3 * T);
    $display("test disable done");
    // a reset while counting must leave the watchdog disabled
    rd(16'h0443, 6);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset output after mid-run reset", 1'b0, sys_rst);
    rd(16'h0045, 6);
    chk("state after mid-run reset", 1'b0, rdat[0]);
    quiet(3 * T);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : testbench
